// File: design/hbd_drive_control.sv
// Top of the H-bridge drive control: input filter, modes, regulation, faults
// Operation
// - Both inputs low: both outputs high impedance; sleep after one millisecond.
// - Input a low, b high: output a low, b high (reverse).
// - Input a high, b low: output a high, b low (forward).
// - Both inputs high: both low-side switches on, braking with slow decay.
// - High-low swaps pass through a dead-time interval of high impedance.
// - Control inputs are deglitched before they affect the outputs.
// - Regulation trip flags when sensed current reaches reference over ten sense resistances.
// - On trip both low sides turn on for a fixed off-time.
// - After off-time the outputs follow the inputs again until next trip.
// - Overcurrent held beyond its deglitch time enters fault, all switches off.
// - Overcurrent fault stays latched until sleep or power removal clears it.
// - Overcurrent watched on every switch and on the sense node separately.
// - Over-temperature turns switches off; resumes by itself after hysteresis cools.
// - Undervoltage disables everything and resets all logic until supply recovers.
// - Active mode needs supply good, inputs not both low, wake elapsed.
// - Inputs low for the sleep delay enter sleep; outputs stay high impedance.
// - Power-up with inputs low goes directly to sleep.
// - Wake needs one input high longer than the wake time.
// - Faults disable the bridge; recovery returns to active mode.
// - Overcurrent must persist about 1.5 microseconds before the fault.
// - Sense-node overcurrent trips above about 0.7 volts.
// - Thermal fault clears about 40 degrees below the shutdown limit.
`timescale 1ns/10ps
module hbd_drive_control #(
   parameter int DEAD_CYCLES = hbd_pkg::DEAD_CYC,
   parameter int OFF_CYCLES = hbd_pkg::OFF_CYC,
   parameter int SLEEP_CYCLES = hbd_pkg::SLEEP_CYC,
   parameter int WAKE_CYCLES = hbd_pkg::WAKE_CYC,
   parameter int OC_CYCLES = hbd_pkg::OC_CYC,
   parameter int IN_CYCLES = hbd_pkg::IN_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic bridge_input_a_i,
   input wire logic bridge_input_b_i,
   input wire logic supply_low_lockout_i,
   input wire logic regulation_trip_i,
   input wire hbd_pkg::hbd_oc_s oc_cmp_i,
   input wire logic thermal_hot_i,
   input wire logic thermal_cool_i,
   output hbd_pkg::hbd_gate_s gate_a_o,
   output hbd_pkg::hbd_gate_s gate_b_o,
   output logic active_o,
   output logic sleep_o,
   output logic overcurrent_fault_o,
   output logic thermal_fault_o,
   output logic regulating_o
);
   import hbd_pkg::*;

   localparam int TW = $clog2(SLEEP_CYCLES + WAKE_CYCLES + OFF_CYCLES + 2);
   localparam int IW = $clog2(IN_CYCLES + 1);
   localparam int OW = $clog2(OC_CYCLES + 1);
   localparam logic [TW-1:0] SLEEP_END = TW'(SLEEP_CYCLES);
   localparam logic [TW-1:0] WAKE_END = TW'(WAKE_CYCLES);
   localparam logic [TW-1:0] OFF_LOAD = TW'(OFF_CYCLES);
   localparam logic [IW-1:0] IN_END = IW'(IN_CYCLES);
   localparam logic [OW-1:0] OC_END = OW'(OC_CYCLES);

   // Whole block reset, also forced by supply undervoltage
   wire logic rst;
   assign rst = srst_i | supply_low_lockout_i;

   // Input deglitch: a raw change must hold IN_CYCLES before it is taken
   logic [1:0] raw;
   logic [1:0] in_reg;
   logic [1:0] in_next;
   logic [IW-1:0] flt_reg;
   logic [IW-1:0] flt_next;
   assign raw = {bridge_input_a_i, bridge_input_b_i};

   always_comb begin
      in_next = in_reg;
      flt_next = '0;
      if (raw != in_reg) begin
         flt_next = flt_reg + 1'b1;
         if (flt_reg >= IN_END - 1'b1) begin
            in_next = raw;
            flt_next = '0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         in_reg <= 2'h0;
         flt_reg <= '0;
      end else begin
         in_reg <= in_next;
         flt_reg <= flt_next;
      end
   end

   wire logic both_low;
   assign both_low = (in_reg == 2'h0);

   // Mode machine: sleep, waking, active; the counter times sleep and wake
   hbd_mode_e mode_reg;
   hbd_mode_e mode_next;
   logic [TW-1:0] tmr_reg;
   logic [TW-1:0] tmr_next;

   always_comb begin
      mode_next = mode_reg;
      tmr_next = '0;
      case (mode_reg)
         HBD_SLEEP: begin
            if (!both_low) begin
               mode_next = HBD_WAKE;
            end
         end
         HBD_WAKE: begin
            // Dropping both inputs before the wake time aborts the wake
            if (both_low) begin
               mode_next = HBD_SLEEP;
            end else if (tmr_reg >= WAKE_END - 1'b1) begin
               mode_next = HBD_ACTIVE;
            end else begin
               tmr_next = tmr_reg + 1'b1;
            end
         end
         HBD_ACTIVE: begin
            if (both_low) begin
               if (tmr_reg >= SLEEP_END - 1'b1) begin
                  mode_next = HBD_SLEEP;
               end else begin
                  tmr_next = tmr_reg + 1'b1;
               end
            end
         end
         default: begin
            mode_next = HBD_SLEEP;
         end
      endcase
   end

   // Reset lands in sleep, so a power-up with inputs low never goes active
   always_ff @(posedge clk_i) begin
      if (rst) begin
         mode_reg <= HBD_SLEEP;
         tmr_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         tmr_reg <= tmr_next;
      end
   end

   wire logic is_active;
   wire logic is_sleep;
   assign is_active = (mode_reg == HBD_ACTIVE);
   assign is_sleep = (mode_reg == HBD_SLEEP);

   // Overcurrent: any switch or the sense node, held past the deglitch time
   wire logic oc_any;
   assign oc_any = |oc_cmp_i;
   logic [OW-1:0] ocd_reg;
   logic [OW-1:0] ocd_next;
   logic ocf_reg;
   logic ocf_next;

   always_comb begin
      ocd_next = '0;
      ocf_next = ocf_reg;
      if (oc_any && is_active) begin
         ocd_next = ocd_reg + 1'b1;
         if (ocd_reg >= OC_END - 1'b1) begin
            ocd_next = ocd_reg;
            ocf_next = 1'b1;
         end
      end
      // Latched until sleep; a fresh trip never coincides since sleep is not active
      if (is_sleep) begin
         ocf_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         ocd_reg <= '0;
         ocf_reg <= 1'b0;
      end else begin
         ocd_reg <= ocd_next;
         ocf_reg <= ocf_next;
      end
   end

   // Thermal shutdown self-recovers once the cool comparator reports hysteresis met
   logic tsd_reg;
   logic tsd_next;
   always_comb begin
      tsd_next = tsd_reg;
      if (thermal_hot_i) begin
         tsd_next = 1'b1;
      end else if (thermal_cool_i) begin
         tsd_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         tsd_reg <= 1'b0;
      end else begin
         tsd_reg <= tsd_next;
      end
   end

   // Fixed off-time after a regulation trip; a trip during off-time is ignored
   logic [TW-1:0] off_reg;
   logic [TW-1:0] off_next;
   wire logic regulating;
   assign regulating = (off_reg != '0);

   always_comb begin
      off_next = off_reg;
      if (!is_active) begin
         off_next = '0;
      end else if (regulating) begin
         off_next = off_reg - 1'b1;
      end else if (regulation_trip_i) begin
         off_next = OFF_LOAD;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         off_reg <= '0;
      end else begin
         off_reg <= off_next;
      end
   end

   // Wanted drive per leg; faults and any non-active mode leave the bridge off
   wire logic bridge_off;
   assign bridge_off = !is_active || ocf_reg || tsd_reg;
   hbd_drv_e want_a;
   hbd_drv_e want_b;

   always_comb begin
      want_a = HBD_HIZ;
      want_b = HBD_HIZ;
      if (bridge_off) begin
         want_a = HBD_HIZ;
         want_b = HBD_HIZ;
      end else if (regulating) begin
         want_a = HBD_LOW;
         want_b = HBD_LOW;
      end else begin
         case (in_reg)
            2'h1: begin
               want_a = HBD_LOW;
               want_b = HBD_HIGH;
            end
            2'h2: begin
               want_a = HBD_HIGH;
               want_b = HBD_LOW;
            end
            2'h3: begin
               want_a = HBD_LOW;
               want_b = HBD_LOW;
            end
            default: begin
               want_a = HBD_HIZ;
               want_b = HBD_HIZ;
            end
         endcase
      end
   end

   // Output legs, each with its own dead-time guard
   hbd_half_bridge #(
      .DEAD_CYCLES(DEAD_CYCLES)
   ) u_leg_a (
      .clk_i(clk_i),
      .srst_i(rst),
      .want_i(want_a),
      .gate_o(gate_a_o)
   );

   hbd_half_bridge #(
      .DEAD_CYCLES(DEAD_CYCLES)
   ) u_leg_b (
      .clk_i(clk_i),
      .srst_i(rst),
      .want_i(want_b),
      .gate_o(gate_b_o)
   );

   // Registered status
   always_ff @(posedge clk_i) begin
      if (rst) begin
         active_o <= 1'b0;
         sleep_o <= 1'b1;
         overcurrent_fault_o <= 1'b0;
         thermal_fault_o <= 1'b0;
         regulating_o <= 1'b0;
      end else begin
         active_o <= is_active;
         sleep_o <= is_sleep;
         overcurrent_fault_o <= ocf_reg;
         thermal_fault_o <= tsd_reg;
         regulating_o <= regulating;
      end
   end
endmodule

// File: design/hbd_half_bridge.sv
// One half-bridge output stage with dead-time insertion
`timescale 1ns/10ps
module hbd_half_bridge #(
   parameter int DEAD_CYCLES = hbd_pkg::DEAD_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire hbd_pkg::hbd_drv_e want_i,
   output hbd_pkg::hbd_gate_s gate_o
);
   import hbd_pkg::*;
   localparam int CW = $clog2(DEAD_CYCLES + 1);
   localparam logic [CW-1:0] DEAD_LOAD = CW'(DEAD_CYCLES);

   hbd_drv_e cur_reg;
   hbd_drv_e cur_next;
   logic [CW-1:0] dead_reg;
   logic [CW-1:0] dead_next;
   hbd_gate_s gate_reg;
   hbd_gate_s gate_next;
   wire logic opposite;

   // A swap between high and low must pass through high impedance first
   assign opposite = (cur_reg == HBD_HIGH && want_i == HBD_LOW) ||
                     (cur_reg == HBD_LOW && want_i == HBD_HIGH);

   // Next drive: hold high impedance while dead time counts down
   always_comb begin
      cur_next = cur_reg;
      dead_next = dead_reg;
      if (dead_reg != '0) begin
         dead_next = dead_reg - 1'b1;
         if (want_i == HBD_HIZ) begin
            dead_next = '0;
         end
         if (dead_reg == CW'(1) && want_i != HBD_HIZ) begin
            cur_next = want_i;
         end
      end else if (opposite) begin
         cur_next = HBD_HIZ;
         dead_next = DEAD_LOAD;
      end else begin
         cur_next = want_i;
      end
      if (cur_next == HBD_HIZ && want_i == HBD_HIZ) begin
         dead_next = '0;
      end
      gate_next.hs_on = (cur_next == HBD_HIGH);
      gate_next.ls_on = (cur_next == HBD_LOW);
   end

   // Registered gates keep both switches of a leg from ever being on together
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cur_reg <= HBD_HIZ;
         dead_reg <= '0;
         gate_reg <= '0;
      end else begin
         cur_reg <= cur_next;
         dead_reg <= dead_next;
         gate_reg <= gate_next;
      end
   end

   assign gate_o = gate_reg;
endmodule

// File: design/hbd_pkg.sv
// Package for the H-bridge drive control: timing constants, states and carriers
package hbd_pkg;
   // Timebase
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_NS = 10;
   // Times in their own units, as printed or chosen
   localparam int DEAD_TIME_NS = 200;
   localparam int OFF_TIME_US = 20;
   localparam int SLEEP_DELAY_US = 1000;
   localparam int WAKE_TIME_US = 250;
   localparam int OC_DEGLITCH_NS = 1500;
   localparam int IN_DEGLITCH_NS = 100;
   // Cycle counts; least times round up
   localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int OFF_CYC = OFF_TIME_US * 1000 / CLK_NS;
   localparam int SLEEP_CYC = SLEEP_DELAY_US * 1000 / CLK_NS;
   localparam int WAKE_CYC = WAKE_TIME_US * 1000 / CLK_NS;
   localparam int OC_CYC = (OC_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int IN_CYC = (IN_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
   // Mode states
   typedef enum logic [1:0] {
      HBD_SLEEP,
      HBD_WAKE,
      HBD_ACTIVE
   } hbd_mode_e;
   // Drive of one half-bridge
   typedef enum logic [1:0] {
      HBD_HIZ,
      HBD_HIGH,
      HBD_LOW
   } hbd_drv_e;
   // Gate controls of one half-bridge
   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } hbd_gate_s;
   // Overcurrent comparator outputs, one per switch plus sense node
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
      logic sense;
   } hbd_oc_s;
endpackage

// File: verif/hbd_ctrl_model.sv
// Controller model that drives the two bridge inputs
`timescale 1ns/10ps
module hbd_ctrl_model (
   input wire logic [1:0] cmd_i,
   input wire logic glitch_i,
   output logic bridge_input_a_o,
   output logic bridge_input_b_o
);
   // Levels follow the command at once, input a inverted while glitch_i is high;
   // no timing of its own, so the bench sets every drive, brake, coast and wake span
   assign bridge_input_a_o = cmd_i[1] ^ glitch_i;
   assign bridge_input_b_o = cmd_i[0];
endmodule

// File: verif/hbd_drive_control_assertions.sv
// Checker of the drive control outputs
`timescale 1ns/10ps
module hbd_drive_control_assertions #(
   parameter int DEAD_CYCLES = 20,
   parameter int OC_CYCLES = 150
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic supply_low_lockout_i,
   input wire hbd_pkg::hbd_oc_s oc_cmp_i,
   input wire logic thermal_hot_i,
   input wire logic thermal_cool_i,
   input wire hbd_pkg::hbd_gate_s gate_a_o,
   input wire hbd_pkg::hbd_gate_s gate_b_o,
   input wire logic active_o,
   input wire logic sleep_o,
   input wire logic overcurrent_fault_o,
   input wire logic thermal_fault_o,
   input wire logic regulating_o
);
   import hbd_pkg::*;
   int hz_cnt;
   int oc_cnt;
   logic last_hs;
   // Undervoltage resets the logic just as the reset pin does
   wire logic rst = srst_i | supply_low_lockout_i;
   wire logic off_a = !gate_a_o.hs_on && !gate_a_o.ls_on;
   wire logic off_b = !gate_b_o.hs_on && !gate_b_o.ls_on;
   // Idle run of leg a, its last drive, and the overcurrent run length
   always_ff @(posedge clk_i) begin
      if (rst) begin
         hz_cnt <= 0;
         oc_cnt <= 0;
         last_hs <= 1'b0;
      end else begin
         hz_cnt <= off_a ? hz_cnt + 1 : 0;
         oc_cnt <= (|oc_cmp_i) ? oc_cnt + 1 : 0;
         last_hs <= gate_a_o.hs_on | (last_hs & !gate_a_o.ls_on);
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst);
   a_no_shoot_through: assert property (!(gate_a_o.hs_on && gate_a_o.ls_on) &&
      !(gate_b_o.hs_on && gate_b_o.ls_on)) else $error("leg with both switches on");
   a_dead_gap: assert property ($rose(gate_a_o.ls_on) && last_hs |->
      hz_cnt >= DEAD_CYCLES) else $error("dead time too short");
   a_sleep_hiz: assert property (sleep_o |-> off_a && off_b && !active_o)
      else $error("driving while asleep");
   a_fault_off: assert property (overcurrent_fault_o || thermal_fault_o |-> off_a && off_b)
      else $error("switch on during fault");
   a_oc_latched: assert property (overcurrent_fault_o |=> overcurrent_fault_o || sleep_o)
      else $error("overcurrent fault cleared without sleep");
   a_oc_deglitch: assert property ($rose(overcurrent_fault_o) |-> oc_cnt >= OC_CYCLES - 1)
      else $error("overcurrent fault before deglitch");
   a_reg_brake: assert property (regulating_o [*3] |-> !gate_a_o.hs_on && !gate_b_o.hs_on)
      else $error("high side on during off time");
   a_cool_resume: assert property (thermal_fault_o && thermal_cool_i && !thermal_hot_i |->
      ##[1:2] !thermal_fault_o) else $error("thermal fault did not clear");
   c_oc_fault: cover property ($rose(overcurrent_fault_o));
   c_regulate: cover property ($rose(regulating_o));
   c_sleep: cover property ($rose(sleep_o));
endmodule
bind hbd_drive_control hbd_drive_control_assertions #(
   .DEAD_CYCLES(DEAD_CYCLES),
   .OC_CYCLES(OC_CYCLES)
) chk_inst (.clk_i(clk_i), .srst_i(srst_i), .supply_low_lockout_i(supply_low_lockout_i),
   .oc_cmp_i(oc_cmp_i), .thermal_hot_i(thermal_hot_i), .thermal_cool_i(thermal_cool_i),
   .gate_a_o(gate_a_o), .gate_b_o(gate_b_o), .active_o(active_o), .sleep_o(sleep_o),
   .overcurrent_fault_o(overcurrent_fault_o), .thermal_fault_o(thermal_fault_o),
   .regulating_o(regulating_o));

// File: verif/tb_top.sv
// Self-checking bench of the drive control
`timescale 1ns/10ps
module tb_top;
   import hbd_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply_low_lockout = 1'b0;
   logic trip = 1'b0;
   logic hot = 1'b0;
   logic cool = 1'b1;
   logic glitch = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic [1:0] c;
   hbd_oc_s oc = '0;
   hbd_gate_s ga, gb;
   logic act, slp, ocf, thf, rgl, in_a, in_b;
   int miscompares = 0;
   int checked = 0;
   int seed = 32'hCAAD;
   wire logic [7:0] gates = {4'h0, ga, gb};
   // Short timings keep the run brief
   hbd_drive_control #(.SLEEP_CYCLES(50), .WAKE_CYCLES(20), .OFF_CYCLES(30))
   hbd_drive_control_inst (.clk_i(clk_i), .srst_i(srst_i), .bridge_input_a_i(in_a),
      .bridge_input_b_i(in_b), .supply_low_lockout_i(supply_low_lockout), .regulation_trip_i(trip),
      .oc_cmp_i(oc), .thermal_hot_i(hot), .thermal_cool_i(cool), .gate_a_o(ga),
      .gate_b_o(gb), .active_o(act), .sleep_o(slp), .overcurrent_fault_o(ocf),
      .thermal_fault_o(thf), .regulating_o(rgl));
   hbd_ctrl_model hbd_ctrl_model_inst (.cmd_i(cmd), .glitch_i(glitch),
      .bridge_input_a_o(in_a), .bridge_input_b_o(in_b));
   // Clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Gate pattern {a.hs, a.ls, b.hs, b.ls} for a command
   function automatic logic [7:0] exp_gates(input logic [1:0] k);
      case (k)
         2'h1: exp_gates = 8'h06;
         2'h2: exp_gates = 8'h09;
         2'h3: exp_gates = 8'h05;
         default: exp_gates = 8'h00;
      endcase
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic drive(input logic [1:0] k, input int n);
      cmd = k;
      cyc(n);
   endtask
   task automatic wake(input logic [1:0] k);
      int n;
      n = 0;
      cmd = k;
      while (act !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("wake span", 8'h1, 8'(n >= 30 && n < 200));
      cyc(45);
      chk("drive after wake", exp_gates(k), gates);
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog, about six times the expected run
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_of_test();
   end
   // Main sequence
   initial begin
      cyc(3);
      srst_i = 1'b0;
      cyc(5);
      chk("power-up", 8'h10, {3'h0, slp, gates[3:0]});
      $display("test powerup done");
      wake(2'h2);
      for (int i = 1; i < 4; i++) begin
         drive(2'(i), 45);
         chk("table", exp_gates(2'(i)), gates);
      end
      for (int i = 0; i < 8; i++) begin
         c = 2'({$random(seed)} % 3 + 1);
         drive(c, 45);
         chk("random", exp_gates(c), gates);
      end
      // Short pulse must be swallowed by the input filter
      glitch = 1'b1;
      cyc(3);
      glitch = 1'b0;
      cyc(30);
      chk("glitch", exp_gates(cmd), gates);
      $display("test drive done");
      drive(2'h2, 45);
      trip = 1'b1;
      cyc(1);
      trip = 1'b0;
      cyc(2);
      chk("regulating", 8'h1, {7'h0, rgl});
      cyc(22);
      chk("off time", 8'h05, gates);
      cyc(50);
      chk("after off", 8'h09, {3'h0, rgl, gates[3:0]});
      $display("test regulation done");
      drive(2'h0, 20);
      chk("coast", 8'h00, gates);
      cyc(60);
      chk("sleep", 8'h1, {7'h0, slp});
      $display("test sleep done");
      for (int i = 0; i < 5; i++) begin
         wake(2'h2);
         oc = hbd_oc_s'(5'h1 << i);
         cyc(100);
         oc = '0;
         cyc(5);
         chk("short overcurrent", 8'h09, {3'h0, ocf, gates[3:0]});
         oc = hbd_oc_s'(5'h1 << i);
         cyc(170);
         oc = '0;
         cyc(20);
         chk("overcurrent latch", 8'h10, {3'h0, ocf, gates[3:0]});
         drive(2'h0, 80);
         chk("overcurrent clear", 8'h1, {6'h0, ocf, slp});
      end
      $display("test overcurrent done");
      wake(2'h2);
      hot = 1'b1;
      cool = 1'b0;
      cyc(3);
      chk("thermal off", 8'h10, {3'h0, thf, gates[3:0]});
      hot = 1'b0;
      cyc(5);
      chk("hysteresis", 8'h10, {3'h0, thf, gates[3:0]});
      cool = 1'b1;
      cyc(45);
      chk("thermal resume", 8'h09, {3'h0, thf, gates[3:0]});
      $display("test thermal done");
      supply_low_lockout = 1'b1;
      cyc(2);
      chk("lockout", 8'h10, {2'h0, act, slp, gates[3:0]});
      supply_low_lockout = 1'b0;
      wake(2'h2);
      $display("test lockout done");
      end_of_test();
   end
endmodule
